// ===== dv/rrsb_host.sv
// APB host model that reads and writes the bank.
// Assumes a single pclk domain shared with the bank.
`timescale 1ns/1ps
module rrsb_host (
    // Clock
    input wire logic pclk,
    // APB master side
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic pready
);
    // Idle bus at time zero
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'hff;
        pwdata = 32'hffffffff;
    end
    // One transfer; the bench watchdog bounds the wait for pready
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        // Released lines show inverted data so stale values cannot pass
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule

// ===== dv/test_rrsb_bank.sv
// Self-checking bench of the result and status bank.
// Assumes the APB host model and read notes checked at pready.
`timescale 1ns/1ps
module test_rrsb_bank;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic fw_we = 1'b0;
    logic [5:0] fw_base = 6'h00;
    logic [23:0] fw_wdata = 24'h000000;
    logic [22:0] st = 23'h000000;
    logic [31:0] rs = 32'h73b2;
    logic [31:0] d;
    logic [32:0] n;
    logic [7:0] mem [0:44];
    logic [32:0] notes [$];
    int err_count = 0;
    int checked = 0;
    int i;
    wire logic psel, penable, pwrite, pready, pslverr, irq;
    wire logic [7:0] paddr;
    wire logic [31:0] pwdata, prdata;
    //////////////////////////////////////////////////////////////////
    always #5 pclk = ~pclk;
    rrsb_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready));
    rrsb_bank #(.ADDR_W(8)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .fw_we(fw_we),
        .fw_base(fw_base), .fw_wdata(fw_wdata), .frontend_run_switch(st[0]),
        .cap_conv_active(st[1]), .res_conv_ready(st[2]), .nvm_busy(st[3]),
        .boot_busy(st[4]), .por_cause_sram(st[5]), .por_cause_config(st[6]),
        .por_cause_wdog(st[7]), .cap_overflow_err(st[8]), .time_digitizer_err(st[9]),
        .resistance_fault_flag(st[10]), .test_bits(st[14:11]),
        .cap_port_fault(st[22:15]), .irq(irq));
    //////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction
    task automatic cmp32(string nm, logic [31:0] e, logic [31:0] s);
        checked++;
        if (e !== s)
        begin
            err_count++;
            $display("[ERR] %s exp %h seen %h", nm, e, s);
        end
    endtask
    task automatic cmp1(string nm, logic e, logic s);
        checked++;
        if (e !== s)
        begin
            err_count++;
            $display("[ERR] %s exp %b seen %b", nm, e, s);
        end
    endtask
    // Each access notes its expected answer before it starts
    task automatic rd(logic [7:0] a, logic [31:0] e, logic er);
        notes.push_back({er, e});
        host.xfer(1'b0, a, 32'h0);
    endtask
    task automatic rdi(logic [5:0] ix, logic [31:0] e);
        rd({ix, 2'b00}, e, 1'b0);
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] v, logic er);
        notes.push_back({er, 32'h0});
        host.xfer(1'b1, a, v);
    endtask
    task automatic fw(logic [5:0] b, logic [23:0] v);
        @(posedge pclk);
        fw_we <= 1'b1;
        fw_base <= b;
        fw_wdata <= v;
        @(posedge pclk);
        fw_we <= 1'b0;
    endtask
    task automatic chk_irq(logic e);
        repeat (3) @(posedge pclk);
        #1 cmp1("irq", e, irq);
    endtask
    task automatic close_out();
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    //////////////////////////////////////////////////////////////////
    // Answer monitor: oldest note against each completion
    always @(posedge pclk)
    begin
        if (pready === 1'b1)
        begin
            n = notes.pop_front();
            cmp32("prdata", n[31:0], prdata);
            cmp1("pslverr", n[32], pslverr);
        end
    end
    // Watchdog: whole run needs a few hundred cycles
    initial
    begin
        #200000;
        err_count++;
        close_out();
    end
    // Main sequence
    initial
    begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rdi(6'h00, 32'h0);
        rdi(rrsb_pkg::IDX_IRQ_ENABLE, 32'h0);
        $display("reset test done");
        for (i = 0; i < 45; i = i + 3)
        begin
            d = rnd();
            if (i != 24)
            begin
                fw(i[5:0], d[23:0]);
                mem[i] = d[7:0];
                mem[i + 1] = d[15:8];
                mem[i + 2] = d[23:16];
            end
        end
        fw(6'h18, 24'h5a5a5a);
        for (i = 0; i < 45; i++)
            if (i < 24 || i > 26)
                rdi(i[5:0], {24'h0, mem[i]});
        wr(8'h0c, 32'h000000ff, 1'b0);
        rdi(6'h03, {24'h0, mem[3]});
        $display("result test done");
        for (i = 0; i < 7; i++)
        begin
            d = (i == 0) ? 32'h00007800 : rnd();
            @(posedge pclk);
            st <= d[22:0];
            repeat (2) @(posedge pclk);
            rdi(rrsb_pkg::IDX_GENERAL_FLAGS, {24'h0, d[7:0]});
            rdi(rrsb_pkg::IDX_ERROR_FLAGS, {24'h0, d[14:8], |d[10:8]});
            rdi(rrsb_pkg::IDX_PORT_FAULT_FLAGS, {24'h0, d[22:15]});
        end
        $display("status test done");
        wr({rrsb_pkg::IDX_IRQ_CLEAR, 2'b00}, 32'h7, 1'b0);
        rdi(rrsb_pkg::IDX_IRQ_STATUS, 32'h0);
        fw(6'h00, 24'h000001);
        chk_irq(1'b0);
        rdi(rrsb_pkg::IDX_IRQ_STATUS, 32'h1);
        wr({rrsb_pkg::IDX_IRQ_ENABLE, 2'b00}, 32'h1, 1'b0);
        chk_irq(1'b1);
        wr({rrsb_pkg::IDX_IRQ_CLEAR, 2'b00}, 32'h1, 1'b0);
        chk_irq(1'b0);
        rdi(rrsb_pkg::IDX_IRQ_CLEAR, 32'h0);
        wr({rrsb_pkg::IDX_IRQ_ENABLE, 2'b00}, 32'h4, 1'b0);
        @(posedge pclk);
        st[22:15] <= 8'h00;
        repeat (3) @(posedge pclk);
        st[15] <= 1'b1;
        chk_irq(1'b1);
        rdi(rrsb_pkg::IDX_IRQ_STATUS, 32'h4);
        wr({rrsb_pkg::IDX_IRQ_CLEAR, 2'b00}, 32'h7, 1'b0);
        @(posedge pclk);
        st[10:8] <= 3'h0;
        repeat (3) @(posedge pclk);
        st[9] <= 1'b1;
        chk_irq(1'b0);
        rdi(rrsb_pkg::IDX_IRQ_STATUS, 32'h2);
        $display("interrupt test done");
        rd(8'hcc, 32'h0, 1'b1);
        rd(8'h01, 32'h0, 1'b1);
        wr(8'hcc, 32'h1, 1'b1);
        $display("error test done");
        close_out();
    end
endmodule

// ===== hw/rrsb_bank.sv
// Readback result and status bank with APB slave and interrupt.
// Assumes firmware write strobe and status inputs synchronous to pclk.
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
module rrsb_bank #(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Firmware result write port
    input wire logic fw_we,
    input wire logic [5:0] fw_base,
    input wire logic [23:0] fw_wdata,
    // Unit state
    input wire logic frontend_run_switch,
    input wire logic cap_conv_active,
    input wire logic res_conv_ready,
    input wire logic nvm_busy,
    input wire logic boot_busy,
    // Reset causes from the reset controller
    input wire logic por_cause_sram,
    input wire logic por_cause_config,
    input wire logic por_cause_wdog,
    // Conversion errors
    input wire logic cap_overflow_err,
    input wire logic time_digitizer_err,
    input wire logic resistance_fault_flag,
    input wire logic [3:0] test_bits,
    input wire logic [7:0] cap_port_fault,
    // Interrupt
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////
    // Storage

    // Slots 24 to 26 exist only so that the byte index equals the bank address divided by four
    logic [7:0] mem_ff [0:rrsb_pkg::IDX_LAST];
    logic [7:0] gen_ff;
    logic [7:0] err_ff;
    logic [7:0] port_ff;
    logic [rrsb_pkg::EVT_W-1:0] ists_ff;
    logic [rrsb_pkg::EVT_W-1:0] ien_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic irq_ff;

    ////////////////////////////////////////////////////////////////////////
    // Firmware write decode

    // Only group starts of result words are accepted; status triple is skipped
    wire fw_mod3 = (fw_base % 6'h03) == 6'h00;
    wire fw_range = fw_base <= rrsb_pkg::IDX_LAST_BASE;
    wire fw_ok = fw_we && fw_mod3 && fw_range && (fw_base != rrsb_pkg::IDX_GENERAL_FLAGS);

    // One byte lane of each triple per storage byte
    genvar g;
    generate
        for (g = 0; g <= rrsb_pkg::IDX_LAST; g++)
        begin : g_byte
            localparam logic [5:0] BASE = 6'(g - (g % 3));
            localparam int LANE = g % 3;
            if (g >= 24 && g <= 26)
            begin : g_sts
                // Status bytes live in their own flops; this slot stays constant
                always_ff @(posedge pclk or negedge presetn)
                begin
                    if (!presetn)
                        mem_ff[g] <= rrsb_pkg::RST_BYTE;
                    else
                        mem_ff[g] <= rrsb_pkg::RST_BYTE;
                end
            end
            else
            begin : g_res
                wire hit = fw_ok && (fw_base == BASE);
                wire [7:0] nxt_byte = hit ? fw_wdata[8*LANE +: 8] : mem_ff[g];
                // Firmware is the only writer; host writes never reach here
                always_ff @(posedge pclk or negedge presetn)
                begin
                    if (!presetn)
                        mem_ff[g] <= rrsb_pkg::RST_BYTE;
                    else
                        mem_ff[g] <= nxt_byte;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Status bytes

    // Reset cause flags come from outside, since the bank itself is cleared
    wire [7:0] nxt_gen = {por_cause_wdog, por_cause_config, por_cause_sram,
        boot_busy, nvm_busy, res_conv_ready, cap_conv_active,
        frontend_run_switch};
    wire [2:0] err_bits = {resistance_fault_flag, time_digitizer_err, cap_overflow_err};
    // Test bits ride along but stay out of the combined error
    wire [7:0] nxt_err = {test_bits, err_bits, |err_bits};
    wire [7:0] nxt_port = cap_port_fault;

    // Status sampled every cycle so a read shows state one cycle old
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            gen_ff <= rrsb_pkg::RST_BYTE;
            err_ff <= rrsb_pkg::RST_BYTE;
            port_ff <= rrsb_pkg::RST_BYTE;
        end
        else
        begin
            gen_ff <= nxt_gen;
            err_ff <= nxt_err;
            port_ff <= nxt_port;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB decode

    // Only the low eight address bits select a register; higher bits must be zero
    wire [5:0] idx = paddr[7:2];
    wire aligned = paddr[1:0] == 2'h0;
    wire high_zero = (ADDR_W > 8) ? (paddr >> 8) == '0 : 1'b1;
    wire in_bank = aligned && high_zero && (idx <= 6'(rrsb_pkg::IDX_LAST));
    wire is_ists = aligned && high_zero && (idx == rrsb_pkg::IDX_IRQ_STATUS);
    wire is_ien = aligned && high_zero && (idx == rrsb_pkg::IDX_IRQ_ENABLE);
    wire is_iclr = aligned && high_zero && (idx == rrsb_pkg::IDX_IRQ_CLEAR);
    // Anything outside the map answers with an error rather than hanging the host
    wire mapped = in_bank || is_ists || is_ien || is_iclr;
    wire access = psel && penable;
    // First access cycle prepares the answer; the second completes it
    wire prep = access && !pready_ff;
    wire done = access && pready_ff;
    wire wr_done = done && pwrite && mapped;

    // Byte selection: status triple overrides the result store
    wire [7:0] bank_byte = (idx == rrsb_pkg::IDX_GENERAL_FLAGS) ? gen_ff :
        (idx == rrsb_pkg::IDX_ERROR_FLAGS) ? err_ff :
        (idx == rrsb_pkg::IDX_PORT_FAULT_FLAGS) ? port_ff :
        mem_ff[idx];
    wire [7:0] rd_byte = in_bank ? bank_byte :
        is_ists ? {5'h00, ists_ff} :
        is_ien ? {5'h00, ien_ff} : 8'h00;
    // Zero outside a read so that a stale byte never shows on the bus
    wire [31:0] nxt_prdata = (prep && !pwrite) ? {24'h000000, rd_byte} : 32'h00000000;

    // One wait state on every transfer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h00000000;
        end
        else
        begin
            pready_ff <= prep;
            pslverr_ff <= prep && !mapped;
            prdata_ff <= nxt_prdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupts

    wire [rrsb_pkg::EVT_W-1:0] evt;
    assign evt[rrsb_pkg::EVT_RESULT] = fw_ok;
    assign evt[rrsb_pkg::EVT_ERROR] = nxt_err[rrsb_pkg::ERR_COMB] && !err_ff[rrsb_pkg::ERR_COMB];
    assign evt[rrsb_pkg::EVT_PORT] = |(nxt_port & ~port_ff);
    wire [rrsb_pkg::EVT_W-1:0] clr = (wr_done && is_iclr) ? pwdata[rrsb_pkg::EVT_W-1:0] : '0;
    // Set beats clear so an event in the clearing cycle survives
    wire [rrsb_pkg::EVT_W-1:0] nxt_ists = (ists_ff & ~clr) | evt;
    wire [rrsb_pkg::EVT_W-1:0] nxt_ien = (wr_done && is_ien) ? pwdata[rrsb_pkg::EVT_W-1:0] : ien_ff;
    wire nxt_irq = |(nxt_ists & nxt_ien);

    // Sticky status, enable, level output from a flop
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ists_ff <= rrsb_pkg::RST_IRQ;
            ien_ff <= rrsb_pkg::RST_IRQ;
            irq_ff <= 1'b0;
        end
        else
        begin
            ists_ff <= nxt_ists;
            ien_ff <= nxt_ien;
            irq_ff <= nxt_irq;
        end
    end

    // Outputs
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign irq = irq_ff;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_prep_read(logic [5:0] i);
        psel && penable && !pready_ff && !pwrite && in_bank && idx == i;
    endsequence

    chk_one_wait: assert property (prep |=> pready_ff ##1 !pready_ff)
        else $error("Transfer did not complete after one wait state");

    chk_run_mirror: assert property (##1 gen_ff[0] == $past(frontend_run_switch))
        else $error("Run switch not mirrored");

    chk_busy_bits: assert property (##1 gen_ff[4:1] ==
        $past({boot_busy, nvm_busy, res_conv_ready, cap_conv_active}))
        else $error("Activity bits out of order");

    chk_por_causes: assert property (##1 gen_ff[7:5] ==
        $past({por_cause_wdog, por_cause_config, por_cause_sram}))
        else $error("Reset cause bits wrong");

    chk_comb_err_or: assert property (
        err_ff[rrsb_pkg::ERR_COMB] == |err_ff[3:rrsb_pkg::ERR_OVFL])
        else $error("Combined error not OR of error bits");

    chk_err_bits: assert property (##1 err_ff[3:1] == $past(err_bits))
        else $error("Error bits misplaced");

    chk_port_fault: assert property (##1 port_ff == $past(cap_port_fault))
        else $error("Port fault byte mismatch");

    chk_status_read: assert property (s_prep_read(rrsb_pkg::IDX_ERROR_FLAGS)
        |=> prdata_ff[7:0] == $past(err_ff) && prdata_ff[31:8] == 24'h000000)
        else $error("Status byte read wrong");

    chk_fw_lanes: assert property (fw_ok && fw_base == rrsb_pkg::IDX_RES_RATIO_A
        |=> mem_ff[39] == $past(fw_wdata[7:0]) && mem_ff[41] == $past(fw_wdata[23:16]))
        else $error("Firmware word not stored in lane order");

    chk_high_half: assert property (fw_ok && fw_base == rrsb_pkg::IDX_DISCHARGE_TIME_HIGH
        |=> mem_ff[27] == $past(fw_wdata[7:0]) && $stable(mem_ff[0]))
        else $error("Upper half not at its own triple");

    chk_bank_ro: assert property (access && pwrite && in_bank && !fw_we
        |=> $stable(mem_ff[3]) && $stable(mem_ff[42]))
        else $error("Host write altered result store");

    chk_sticky_set: assert property (|evt |=> (ists_ff & $past(evt)) == $past(evt))
        else $error("Event lost from sticky status");

    chk_irq_level: assert property (irq_ff == |(ists_ff & ien_ff))
        else $error("Interrupt level disagrees with status and enable");

    // Host reads of result bytes and of the status triple
    sequence s_prep_result;
        psel && penable && !pready_ff && !pwrite && in_bank &&
            (idx < rrsb_pkg::IDX_GENERAL_FLAGS || idx > rrsb_pkg::IDX_PORT_FAULT_FLAGS);
    endsequence

    chk_result_read: assert property (s_prep_result
        |=> prdata_ff[7:0] == $past(mem_ff[idx]) && prdata_ff[31:8] == 24'h000000)
        else $error("Result byte read wrong");

    chk_gen_read: assert property (s_prep_read(rrsb_pkg::IDX_GENERAL_FLAGS)
        |=> prdata_ff[7:0] == $past(gen_ff))
        else $error("General flag byte read wrong");

    chk_port_read: assert property (s_prep_read(rrsb_pkg::IDX_PORT_FAULT_FLAGS)
        |=> prdata_ff[7:0] == $past(port_ff))
        else $error("Port fault byte read wrong");

    // Error byte: test bits pass through but never raise the combined flag
    chk_test_bits: assert property (##1 err_ff[7:4] == $past(test_bits))
        else $error("Test bits not passed through");

    chk_comb_sources: assert property (##1 err_ff[rrsb_pkg::ERR_COMB] ==
        $past(cap_overflow_err || time_digitizer_err || resistance_fault_flag))
        else $error("Combined error follows test bits or misses an error");

    // Firmware stores: lane order, split words, refused status triple
    sequence s_fw_store(logic [5:0] b);
        fw_ok && fw_base == b;
    endsequence

    chk_low_lanes: assert property (s_fw_store(rrsb_pkg::IDX_DISCHARGE_TIME_LOW)
        |=> mem_ff[1] == $past(fw_wdata[15:8]) && mem_ff[2] == $past(fw_wdata[23:16]))
        else $error("Low half of word zero not in lane order");

    chk_high_lanes: assert property (s_fw_store(rrsb_pkg::IDX_CAP_RATIO_ONE_HIGH)
        |=> mem_ff[30] == $past(fw_wdata[7:0]) && mem_ff[32] == $past(fw_wdata[23:16])
        && $stable(mem_ff[3]))
        else $error("Upper half of word one misplaced");

    chk_status_skip: assert property (fw_we && fw_base == rrsb_pkg::IDX_GENERAL_FLAGS
        |=> $stable(mem_ff[23]) && $stable(mem_ff[27]) && !$past(fw_ok))
        else $error("Firmware write landed on the status triple");

    chk_fw_idle: assert property (!fw_we |=> $stable(mem_ff[0]) && $stable(mem_ff[44]))
        else $error("Result store changed without a firmware write");

    // Interrupt registers and bus error answers
    sequence s_clear_done;
        wr_done && is_iclr;
    endsequence

    chk_clear_bits: assert property (s_clear_done
        |=> (ists_ff & $past(pwdata[rrsb_pkg::EVT_W-1:0] & ~evt)) == 3'h0)
        else $error("Cleared status bit still set");

    chk_enable_write: assert property (wr_done && is_ien
        |=> ien_ff == $past(pwdata[rrsb_pkg::EVT_W-1:0]))
        else $error("Interrupt enable write lost");

    chk_unmapped_error: assert property (prep && !mapped
        |=> pslverr_ff && pready_ff && prdata_ff == 32'h00000000)
        else $error("Unmapped access not answered with error");

    chk_mapped_ok: assert property (prep && mapped |=> !pslverr_ff)
        else $error("Mapped access flagged as error");

endmodule

// ===== hw/rrsb_pkg.sv
// Constants of the readback result and status bank.
// Assumes an APB master with 32-bit data, one register byte per word.
package rrsb_pkg;
    // Byte indices of the bank; byte address is four times the index
    localparam int unsigned IDX_LAST = 44;
    localparam logic [5:0] IDX_DISCHARGE_TIME_LOW = 6'h00;
    localparam logic [5:0] IDX_CAP_RATIO_ONE_LOW = 6'h03;
    localparam logic [5:0] IDX_CAP_RATIO_TWO = 6'h06;
    localparam logic [5:0] IDX_CAP_RATIO_THREE = 6'h09;
    localparam logic [5:0] IDX_CAP_RATIO_FOUR = 6'h0c;
    localparam logic [5:0] IDX_CAP_RATIO_FIVE = 6'h0f;
    localparam logic [5:0] IDX_CAP_RATIO_SIX = 6'h12;
    localparam logic [5:0] IDX_CAP_RATIO_SEVEN = 6'h15;
    localparam logic [5:0] IDX_RES_RATIO_A = 6'h27;
    localparam logic [5:0] IDX_GENERAL_FLAGS = 6'h18;
    localparam logic [5:0] IDX_ERROR_FLAGS = 6'h19;
    localparam logic [5:0] IDX_PORT_FAULT_FLAGS = 6'h1a;
    localparam logic [5:0] IDX_DISCHARGE_TIME_HIGH = 6'h1b;
    localparam logic [5:0] IDX_CAP_RATIO_ONE_HIGH = 6'h1e;
    localparam logic [5:0] IDX_SPARE_RESULT_EIGHT = 6'h21;
    localparam logic [5:0] IDX_SPARE_RESULT_NINE = 6'h24;
    localparam logic [5:0] IDX_LAST_BASE = 6'h2a; // Second resistance ratio, last word start
    // Interrupt registers
    localparam logic [5:0] IDX_IRQ_STATUS = 6'h30;
    localparam logic [5:0] IDX_IRQ_ENABLE = 6'h31;
    localparam logic [5:0] IDX_IRQ_CLEAR = 6'h32;
    // Interrupt event bits
    localparam int unsigned EVT_RESULT = 0;
    localparam int unsigned EVT_ERROR = 1;
    localparam int unsigned EVT_PORT = 2;
    localparam int unsigned EVT_W = 3;
    // Error flag byte fields
    localparam int unsigned ERR_COMB = 0;
    localparam int unsigned ERR_OVFL = 1;
    localparam int unsigned ERR_TEST_LO = 4;
    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [EVT_W-1:0] RST_IRQ = 3'h0;
endpackage
